/* File: rtl/clock_source_pkg.sv */
// package: register map, field layouts, reset values and codes of the clock source unit
package clock_source_pkg;
	localparam int ADDR_W = 2;
	localparam logic [1:0] ADDR_CTRL_ONE = 2'h0;
	localparam logic [1:0] ADDR_CTRL_TWO = 2'h1;
	localparam logic [1:0] ADDR_TRIM = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;
	// control one fields
	localparam int SRC_SEL_HI = 7;
	localparam int SRC_SEL_LO = 6;
	localparam int REF_DIV_HI = 5;
	localparam int REF_DIV_LO = 3;
	localparam int REF_SEL_BIT = 2;
	localparam int IR_OUT_EN_BIT = 1;
	localparam int IRSTEN_BIT = 0;
	// control two fields
	localparam int BUS_DIV_HI = 7;
	localparam int BUS_DIV_LO = 6;
	localparam int RANGE_BIT = 5;
	localparam int GAIN_BIT = 4;
	localparam int LPWR_BIT = 3;
	localparam int OSCREQ_BIT = 2;
	localparam int ER_OUT_EN_BIT = 1;
	localparam int ERSTEN_BIT = 0;
	// status fields
	localparam int REFST_BIT = 4;
	localparam int MODEST_HI = 3;
	localparam int MODEST_LO = 2;
	localparam int OSCRDY_BIT = 1;
	localparam int FINE_TRIM_BIT = 0;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
	localparam logic [7:0] CTRL_TWO_RESET = 8'h40;
	localparam logic [7:0] TRIM_DEBUG_RESET = 8'h80;
	localparam logic [7:0] STATUS_RESET = 8'h10;
	localparam logic [2:0] REF_DIV_HIGH_FIRST_RESERVED = 3'h6;
	localparam logic [3:0] REF_DIV_HIGH_SHIFT_BASE = 4'h5;
	localparam int SYNC_STAGES = 2;
	localparam int OSC_STARTUP_CYCLES = 4096;
	typedef enum logic [1:0] {
		SRC_LOOP = 2'b00,
		SRC_INTERNAL = 2'b01,
		SRC_EXTERNAL = 2'b10,
		SRC_RESERVED = 2'b11
	} clock_source_t;
endpackage : clock_source_pkg

/* File: rtl/clock_divider.sv */
// power-of-two enable divider: one-cycle pulse every 2**shift source ticks
`timescale 1ns/1ps
module clock_divider #(
	parameter int SHIFT_W = 4
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_tick,
	input wire logic [SHIFT_W-1:0] i_shift,
	output logic o_tick
);
	localparam int CNT_W = (1 << SHIFT_W);
	initial begin
		if (SHIFT_W < 1 || SHIFT_W > 4) $error("clock_divider: SHIFT_W out of range");
	end
	logic [CNT_W-1:0] count_q, count_d;
	logic tick_q, tick_d;
	logic [CNT_W-1:0] limit;
	always_comb begin
		limit = (CNT_W'(1) << i_shift) - CNT_W'(1);
		count_d = count_q;
		tick_d = 1'b0;
		if (i_tick) begin
			// new ratio takes effect at once; a count already at or above the new limit gives a pulse on the next source tick
			if (count_q >= limit) begin
				count_d = '0;
				tick_d = 1'b1;
			end else begin
				count_d = count_q + CNT_W'(1);
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_q <= '0;
			tick_q <= 1'b0;
		end else begin
			count_q <= count_d;
			tick_q <= tick_d;
		end
	end
	assign o_tick = tick_q;
endmodule : clock_divider

/* File: rtl/status_sync.sv */
// multi-stage synchroniser that makes status fields lag their controlling bits
`timescale 1ns/1ps
module status_sync #(
	parameter int WIDTH = 3,
	parameter int STAGES = 2
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_reset_value,
	input wire logic [WIDTH-1:0] i_data,
	output logic [WIDTH-1:0] o_data
);
	initial begin
		if (STAGES < 2) $error("status_sync: need at least two stages");
	end
	logic [WIDTH-1:0] stage_q [STAGES];
	logic [WIDTH-1:0] stage_d [STAGES];
	logic loaded_q;
	always_comb begin
		stage_d[0] = i_data;
		for (int i = 1; i < STAGES; i++) begin
			stage_d[i] = stage_q[i-1];
		end
	end
	// async reset loads constants; the chosen reset value is taken on the first clocked edge
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_q[i] <= '0;
			end
			loaded_q <= 1'b0;
		end else if (!loaded_q) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_q[i] <= i_reset_value;
			end
			loaded_q <= 1'b1;
		end else begin
			for (int i = 0; i < STAGES; i++) begin
				stage_q[i] <= stage_d[i];
			end
		end
	end
	assign o_data = stage_q[STAGES-1];
endmodule : status_sync

/* File: rtl/clock_source_unit.sv */
// clock source unit: control registers, source select, dividers and oscillator controls
//
// Operation
// - source field: 00 loop, 01 internal, 10 external; 11 acts as 00
// - low range divides 1..128; high range 32..1024, codes 6,7 reserved
// - reference select bit 1 feeds internal reference to loop, 0 external
// - internal reference clock out active only while its enable is set
// - internal reference runs in stop only if stop-enable and enable set before stop
// - bus divider codes give divide by 1,2,4,8; reset is divide by 2
// - range bit requests high-frequency oscillator range when 1
// - gain bit selects high-gain oscillator operation when 1
// - low-power bit shuts loop in bypass modes unless debug mode active
// - oscillator request bit asks for crystal oscillator when 1, plain clock when 0
// - external reference clock out active only while its enable is set
// - external reference runs in stop only if stop-enable and enable set before stop
// - eight-bit trim sets internal reference period, larger value longer period
// - trim loads factory value at reset, or 0x80 in debug mode
// - an extra fine trim bit lives in the status and control register
// - clock mode status follows source select after synchronisation delay
// - reference status follows reference select after synchronisation delay
// - oscillator ready sets after start-up; clears when enable or request clears
// - fine trim set lengthens period by smallest step, clear shortens it
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module clock_source_unit
	import clock_source_pkg::*;
#(
	parameter int STARTUP_CYCLES = OSC_STARTUP_CYCLES,
	parameter logic [7:0] FACTORY_TRIM = 8'h80,
	parameter logic FACTORY_FINE_TRIM = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [7:0] o_rdata,
	input wire logic i_debug_mode,
	input wire logic i_stop_mode,
	input wire logic i_loop_tick,
	input wire logic i_internal_ref_tick,
	input wire logic i_external_ref_tick,
	input wire logic i_osc_clock_valid,
	output logic o_bus_clock_tick,
	output logic o_loop_reference_tick,
	output logic o_internal_ref_clock_out,
	output logic o_external_ref_clock_out,
	output logic o_loop_enable,
	output logic o_internal_ref_enable,
	output logic o_osc_enable,
	output logic o_oscillator_request,
	output logic o_oscillator_range_select,
	output logic o_oscillator_gain_select,
	output logic [8:0] o_internal_ref_trim
);
	localparam int STARTUP_W = $clog2(STARTUP_CYCLES + 1);
	initial begin
		if (STARTUP_CYCLES < 1) $error("clock_source_unit: STARTUP_CYCLES must be positive");
	end

	function automatic clock_source_t decode_source(input logic [1:0] code);
		// reserved code falls back to the loop output
		return (code == SRC_RESERVED) ? SRC_LOOP : clock_source_t'(code);
	endfunction : decode_source

	// registers and state
	logic [7:0] ctrl_one_q, ctrl_one_d;
	logic [7:0] ctrl_two_q, ctrl_two_d;
	logic [7:0] trim_q, trim_d;
	logic fine_trim_q, fine_trim_d;
	logic [7:0] rdata_q, rdata_d;
	logic trim_loaded_q, trim_loaded_d;
	logic stop_q, stop_d;
	logic ir_stop_keep_q, ir_stop_keep_d;
	logic er_stop_keep_q, er_stop_keep_d;
	logic osc_ready_q, osc_ready_d;
	logic [STARTUP_W-1:0] startup_q, startup_d;
	clock_source_t source_q, source_d;
	logic [1:0] bus_clock_divider_q, bus_clock_divider_d;

	logic [2:0] status_now;
	logic [2:0] status_sync_out;
	logic [2:0] status_reset_value;
	logic [3:0] ref_shift;
	logic ref_div_tick;
	logic bus_div_tick;
	logic source_tick;
	logic [7:0] status_read;

	always_comb begin
		ctrl_one_d = ctrl_one_q;
		ctrl_two_d = ctrl_two_q;
		trim_d = trim_q;
		fine_trim_d = fine_trim_q;
		trim_loaded_d = 1'b1;
		rdata_d = rdata_q;
		if (!trim_loaded_q) begin
			// trim is caught once after reset release, from factory or debug default
			trim_d = i_debug_mode ? TRIM_DEBUG_RESET : FACTORY_TRIM;
			fine_trim_d = i_debug_mode ? 1'b0 : FACTORY_FINE_TRIM;
		end
		if (i_write) begin
			unique case (i_addr)
				ADDR_CTRL_ONE: ctrl_one_d = i_wdata;
				ADDR_CTRL_TWO: ctrl_two_d = i_wdata;
				ADDR_TRIM: trim_d = i_wdata;
				ADDR_STATUS: fine_trim_d = i_wdata[FINE_TRIM_BIT];
			endcase
		end
		if (i_read) begin
			unique case (i_addr)
				ADDR_CTRL_ONE: rdata_d = ctrl_one_q;
				ADDR_CTRL_TWO: rdata_d = ctrl_two_q;
				ADDR_TRIM: rdata_d = trim_q;
				ADDR_STATUS: rdata_d = status_read;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_one_q <= CTRL_ONE_RESET;
			ctrl_two_q <= CTRL_TWO_RESET;
			trim_q <= TRIM_DEBUG_RESET;
			fine_trim_q <= 1'b0;
			trim_loaded_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ctrl_one_q <= ctrl_one_d;
			ctrl_two_q <= ctrl_two_d;
			trim_q <= trim_d;
			fine_trim_q <= fine_trim_d;
			trim_loaded_q <= trim_loaded_d;
			rdata_q <= rdata_d;
		end
	end

	// status lags control through the synchroniser
	assign status_now = {ctrl_one_q[REF_SEL_BIT],
		decode_source(ctrl_one_q[SRC_SEL_HI:SRC_SEL_LO])};
	assign status_reset_value = {STATUS_RESET[REFST_BIT], STATUS_RESET[MODEST_HI:MODEST_LO]};

	status_sync #(
		.WIDTH(3),
		.STAGES(SYNC_STAGES)
	) u_status_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_reset_value(status_reset_value),
		.i_data(status_now),
		.o_data(status_sync_out)
	);

	always_comb begin
		status_read = 8'h00;
		status_read[REFST_BIT] = status_sync_out[2];
		status_read[MODEST_HI:MODEST_LO] = status_sync_out[1:0];
		status_read[OSCRDY_BIT] = osc_ready_q;
		status_read[FINE_TRIM_BIT] = fine_trim_q;
	end

	// oscillator start-up and stop-mode capture
	logic osc_wanted;
	logic external_in_use;
	always_comb begin
		external_in_use = ctrl_two_q[ER_OUT_EN_BIT] || !ctrl_one_q[REF_SEL_BIT]
			|| (source_q == SRC_EXTERNAL);
		osc_wanted = ctrl_two_q[OSCREQ_BIT] && ctrl_two_q[ER_OUT_EN_BIT];
		stop_d = i_stop_mode;
		ir_stop_keep_d = ir_stop_keep_q;
		er_stop_keep_d = er_stop_keep_q;
		if (i_stop_mode && !stop_q) begin
			// enables are sampled at the entry into stop, not during it
			ir_stop_keep_d = ctrl_one_q[IRSTEN_BIT] && ctrl_one_q[IR_OUT_EN_BIT];
			er_stop_keep_d = ctrl_two_q[ERSTEN_BIT] && ctrl_two_q[ER_OUT_EN_BIT];
		end
		startup_d = startup_q;
		osc_ready_d = osc_ready_q;
		if (!osc_wanted) begin
			osc_ready_d = 1'b0;
			startup_d = '0;
		end else if (external_in_use && ctrl_two_q[OSCREQ_BIT] && !osc_ready_q
				&& i_osc_clock_valid) begin
			if (startup_q == STARTUP_W'(STARTUP_CYCLES - 1)) begin
				osc_ready_d = 1'b1;
			end else begin
				startup_d = startup_q + STARTUP_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stop_q <= 1'b0;
			ir_stop_keep_q <= 1'b0;
			er_stop_keep_q <= 1'b0;
			startup_q <= '0;
			osc_ready_q <= 1'b0;
		end else begin
			stop_q <= stop_d;
			ir_stop_keep_q <= ir_stop_keep_d;
			er_stop_keep_q <= er_stop_keep_d;
			startup_q <= startup_d;
			osc_ready_q <= osc_ready_d;
		end
	end

	// external reference divider for the loop
	always_comb begin
		if (ctrl_two_q[RANGE_BIT]) begin
			// reserved high-range codes clamp to the largest legal ratio
			ref_shift = (ctrl_one_q[REF_DIV_HI:REF_DIV_LO] >= REF_DIV_HIGH_FIRST_RESERVED)
				? REF_DIV_HIGH_SHIFT_BASE + 4'(REF_DIV_HIGH_FIRST_RESERVED - 3'h1)
				: REF_DIV_HIGH_SHIFT_BASE + 4'(ctrl_one_q[REF_DIV_HI:REF_DIV_LO]);
		end else begin
			ref_shift = 4'(ctrl_one_q[REF_DIV_HI:REF_DIV_LO]);
		end
	end

	clock_divider #(
		.SHIFT_W(4)
	) u_ref_divider (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_tick(i_external_ref_tick),
		.i_shift(ref_shift),
		.o_tick(ref_div_tick)
	);

	// source and bus divider are switched only on a bus period boundary
	always_comb begin
		source_d = source_q;
		bus_clock_divider_d = bus_clock_divider_q;
		if (bus_div_tick) begin
			source_d = decode_source(ctrl_one_q[SRC_SEL_HI:SRC_SEL_LO]);
			bus_clock_divider_d = ctrl_two_q[BUS_DIV_HI:BUS_DIV_LO];
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			source_q <= SRC_LOOP;
			bus_clock_divider_q <= CTRL_TWO_RESET[BUS_DIV_HI:BUS_DIV_LO];
		end else begin
			source_q <= source_d;
			bus_clock_divider_q <= bus_clock_divider_d;
		end
	end

	always_comb begin
		unique case (source_q)
			SRC_INTERNAL: source_tick = i_internal_ref_tick;
			SRC_EXTERNAL: source_tick = i_external_ref_tick;
			default: source_tick = i_loop_tick;
		endcase
	end

	clock_divider #(
		.SHIFT_W(2)
	) u_bus_divider (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_tick(source_tick),
		.i_shift(bus_clock_divider_q),
		.o_tick(bus_div_tick)
	);

	// registered outputs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_bus_clock_tick <= 1'b0;
			o_loop_reference_tick <= 1'b0;
			o_internal_ref_clock_out <= 1'b0;
			o_external_ref_clock_out <= 1'b0;
			o_loop_enable <= 1'b1;
			o_internal_ref_enable <= 1'b1;
			o_osc_enable <= 1'b0;
			o_oscillator_request <= 1'b0;
			o_oscillator_range_select <= 1'b0;
			o_oscillator_gain_select <= 1'b0;
			o_internal_ref_trim <= {TRIM_DEBUG_RESET, 1'b0};
		end else begin
			o_bus_clock_tick <= bus_div_tick && !i_stop_mode;
			o_loop_reference_tick <= ctrl_one_q[REF_SEL_BIT] ? i_internal_ref_tick
				: ref_div_tick;
			o_internal_ref_clock_out <= i_internal_ref_tick && ctrl_one_q[IR_OUT_EN_BIT]
				&& (!i_stop_mode || ir_stop_keep_q);
			o_external_ref_clock_out <= i_external_ref_tick && ctrl_two_q[ER_OUT_EN_BIT]
				&& (!i_stop_mode || er_stop_keep_q);
			o_loop_enable <= !i_stop_mode && !(source_q != SRC_LOOP
				&& ctrl_two_q[LPWR_BIT] && !i_debug_mode);
			o_internal_ref_enable <= i_stop_mode ? ir_stop_keep_q
				: (ctrl_one_q[IR_OUT_EN_BIT] || ctrl_one_q[REF_SEL_BIT]
				|| source_q == SRC_INTERNAL);
			o_osc_enable <= i_stop_mode ? er_stop_keep_q
				: external_in_use;
			o_oscillator_request <= ctrl_two_q[OSCREQ_BIT];
			o_oscillator_range_select <= ctrl_two_q[RANGE_BIT];
			o_oscillator_gain_select <= ctrl_two_q[GAIN_BIT];
			o_internal_ref_trim <= {trim_q, fine_trim_q};
		end
	end

	assign o_rdata = rdata_q;
endmodule : clock_source_unit

/* File: sim/clock_source_monitor.sv */
// checker: port-level relations of the clock source unit
`timescale 1ns/1ps
module clock_source_monitor
	import clock_source_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	input wire logic [7:0] o_rdata,
	input wire logic i_internal_ref_tick,
	input wire logic i_external_ref_tick,
	input wire logic o_internal_ref_clock_out,
	input wire logic o_external_ref_clock_out,
	input wire logic o_oscillator_request,
	input wire logic o_oscillator_range_select,
	input wire logic o_oscillator_gain_select,
	input wire logic [8:0] o_internal_ref_trim
);
	default clocking mon_cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	// trim output lags the register by one cycle, so it equals read data in the answer cycle
	trim_read_a: assert property ($past(i_read && i_addr == ADDR_TRIM)
		|-> o_rdata == o_internal_ref_trim[8:1]) else $error("trim read mismatch");
	status_read_a: assert property ($past(i_read && i_addr == ADDR_STATUS)
		|-> o_rdata[7:5] == 3'h0 && o_rdata[0] == o_internal_ref_trim[0])
		else $error("status read mismatch");
	// register updates on the strobe edge, the output flop one edge later
	trim_write_a: assert property ($past(i_write && i_addr == ADDR_TRIM, 2)
		|-> o_internal_ref_trim[8:1] == $past(i_wdata, 2)) else $error("trim write lost");
	fine_trim_a: assert property ($past(i_write && i_addr == ADDR_STATUS, 2)
		|-> o_internal_ref_trim[0] == $past(i_wdata[FINE_TRIM_BIT], 2))
		else $error("fine trim lost");
	osc_ctrl_a: assert property ($past(i_write && i_addr == ADDR_CTRL_TWO, 2)
		|-> {o_oscillator_range_select, o_oscillator_gain_select, o_oscillator_request}
		== {$past(i_wdata[RANGE_BIT], 2), $past(i_wdata[GAIN_BIT], 2),
		$past(i_wdata[OSCREQ_BIT], 2)})
		else $error("oscillator controls wrong");
	osc_hold_a: assert property ($changed(o_oscillator_request)
		|-> $past(i_write && i_addr == ADDR_CTRL_TWO, 2)) else $error("request moved alone");
	irclk_cause_a: assert property (o_internal_ref_clock_out
		|-> $past(i_internal_ref_tick)) else $error("internal out without tick");
	erclk_cause_a: assert property (o_external_ref_clock_out
		|-> $past(i_external_ref_tick)) else $error("external out without tick");
endmodule : clock_source_monitor

bind clock_source_unit clock_source_monitor u_monitor (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
	.i_internal_ref_tick(i_internal_ref_tick), .i_external_ref_tick(i_external_ref_tick),
	.o_internal_ref_clock_out(o_internal_ref_clock_out),
	.o_external_ref_clock_out(o_external_ref_clock_out),
	.o_oscillator_request(o_oscillator_request),
	.o_oscillator_range_select(o_oscillator_range_select),
	.o_oscillator_gain_select(o_oscillator_gain_select),
	.o_internal_ref_trim(o_internal_ref_trim));

/* File: sim/test_clock_source_unit.sv */
// testbench: registers, source and divider selection, gating and status of the unit
`timescale 1ns/1ps
module test_clock_source_unit import clock_source_pkg::*;;
	logic i_clk, i_reset_n, i_write, i_read, i_debug_mode, i_stop_mode, i_osc_clock_valid;
	logic i_loop_tick, i_internal_ref_tick, i_external_ref_tick;
	logic [ADDR_W-1:0] i_addr;
	logic [7:0] i_wdata, o_rdata, cyc_q, rd_q;
	logic o_bus_clock_tick, o_loop_reference_tick, o_internal_ref_clock_out;
	logic o_external_ref_clock_out, o_loop_enable, o_internal_ref_enable, o_osc_enable;
	logic o_oscillator_request, o_oscillator_range_select, o_oscillator_gain_select;
	logic [8:0] o_internal_ref_trim;
	logic [15:0] n_bus, n_ref, n_ir, n_er;
	int n_mismatch, tests_run;
	int src_per[4] = '{2, 1, 4, 2};
	// {range, divider code} and the resulting loop reference period in cycles
	logic [3:0] rcfg[4] = '{4'h0, 4'h7, 4'h8, 4'hA};
	int rper[4] = '{4, 512, 128, 512};
	// {ctrl one, ctrl two, internal out count, external out count}
	logic [31:0] gate[4] = '{32'h0440_0000, 32'h0642_4010, 32'h0742_4000, 32'h0543_0010};
	// {ctrl one, ctrl two, debug, loop enable}
	logic [17:0] pwr_cfg[4] = '{{16'h4448, 2'b00}, {16'h4448, 2'b11}, {16'h0448, 2'b01},
		{16'h4440, 2'b01}};
	// {internal ref enable, oscillator enable} at the end of each gating step
	logic [1:0] ref_en[4] = '{2'b10, 2'b11, 2'b10, 2'b01};

	clock_source_unit #(.STARTUP_CYCLES(4)) u_dut (.*);

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// source ticks: loop every 2nd cycle, internal every cycle, external every 4th
	always @(posedge i_clk) begin
		cyc_q <= cyc_q + 8'h01;
		i_loop_tick <= cyc_q[0];
		i_internal_ref_tick <= 1'b1;
		i_external_ref_tick <= (cyc_q[1:0] == 2'h3);
	end

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clk);
		i_write <= 1'b0;
	endtask : wr

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rchk(input logic [1:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clk);
		i_read <= 1'b0;
		#1 rd_q = o_rdata;
		chk($sformatf("register %0d", a), {8'h00, e}, {8'h00, rd_q});
	endtask : rchk

	// counts are taken over whole periods so the phase of each divider does not matter
	task automatic count(input int s, input int n);
		repeat (s) @(posedge i_clk);
		n_bus = 16'h0000;
		n_ref = 16'h0000;
		n_ir = 16'h0000;
		n_er = 16'h0000;
		repeat (n) begin
			@(posedge i_clk);
			#1;
			n_bus = n_bus + 16'(o_bus_clock_tick);
			n_ref = n_ref + 16'(o_loop_reference_tick);
			n_ir = n_ir + 16'(o_internal_ref_clock_out);
			n_er = n_er + 16'(o_external_ref_clock_out);
		end
	endtask : count

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	initial begin
		#300000;
		n_mismatch++;
		end_of_test();
	end

	initial begin
		i_reset_n = 1'b0;
		i_debug_mode = 1'b1;
		i_stop_mode = 1'b0;
		i_osc_clock_valid = 1'b1;
		i_write = 1'b0;
		i_read = 1'b0;
		i_addr = 2'h0;
		i_wdata = 8'h00;
		cyc_q = 8'h00;
		i_loop_tick = 1'b0;
		i_internal_ref_tick = 1'b0;
		i_external_ref_tick = 1'b0;
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		#1 chk("trim out", 16'h0100, {7'h00, o_internal_ref_trim});
		rchk(ADDR_CTRL_ONE, 8'h04);
		rchk(ADDR_CTRL_TWO, 8'h40);
		rchk(ADDR_TRIM, 8'h80);
		rchk(ADDR_STATUS, 8'h10);
		@(posedge i_clk);
		i_debug_mode <= 1'b0;
		$display("test reset values done");
		wr(ADDR_TRIM, 8'h5A);
		wr(ADDR_STATUS, 8'hFF);
		// the trim output flop follows the register one edge later
		@(posedge i_clk);
		#1 chk("trim out", 16'h00B5, {7'h00, o_internal_ref_trim});
		rchk(ADDR_STATUS, 8'h11);
		wr(ADDR_CTRL_TWO, 8'h74);
		@(posedge i_clk);
		#1 chk("oscillator range", 16'h0001, {15'h0, o_oscillator_range_select});
		chk("oscillator gain", 16'h0001, {15'h0, o_oscillator_gain_select});
		chk("oscillator request", 16'h0001, {15'h0, o_oscillator_request});
		wr(ADDR_CTRL_TWO, 8'h40);
		$display("test register access done");
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_CTRL_ONE, {s[1:0], 6'h04});
			count(40, 128);
			chk("bus ticks", 16'(64 / src_per[s]), n_bus);
			rchk(ADDR_STATUS, {4'h1, (s == 3) ? 2'h0 : s[1:0], 2'h1});
		end
		wr(ADDR_CTRL_ONE, 8'h44);
		for (int b = 0; b < 4; b++) begin
			wr(ADDR_CTRL_TWO, {b[1:0], 6'h00});
			count(40, 128);
			chk("bus ticks", 16'(128 >> b), n_bus);
		end
		$display("test source and bus divider done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL_TWO, {2'h1, rcfg[i][3], 5'h00});
			wr(ADDR_CTRL_ONE, {2'h0, rcfg[i][2:0], 3'h0});
			count(1024, 2048);
			chk("loop reference ticks", 16'(2048 / rper[i]), n_ref);
		end
		rchk(ADDR_STATUS, 8'h01);
		wr(ADDR_CTRL_ONE, 8'h04);
		count(40, 256);
		chk("loop reference ticks", 16'd256, n_ref);
		$display("test reference divider done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL_ONE, gate[i][31:24]);
			wr(ADDR_CTRL_TWO, gate[i][23:16]);
			@(posedge i_clk);
			i_stop_mode <= i[1];
			count(8, 64);
			chk("internal ref out", {8'h00, gate[i][15:8]}, n_ir);
			chk("external ref out", {8'h00, gate[i][7:0]}, n_er);
			chk("internal ref enable", {15'h0, ref_en[i][1]}, {15'h0, o_internal_ref_enable});
			chk("oscillator enable", {15'h0, ref_en[i][0]}, {15'h0, o_osc_enable});
			@(posedge i_clk);
			i_stop_mode <= 1'b0;
		end
		$display("test reference gating done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL_ONE, pwr_cfg[i][17:10]);
			wr(ADDR_CTRL_TWO, pwr_cfg[i][9:2]);
			@(posedge i_clk);
			i_debug_mode <= pwr_cfg[i][1];
			count(16, 1);
			chk("loop enable", {15'h0, pwr_cfg[i][0]}, {15'h0, o_loop_enable});
		end
		@(posedge i_clk);
		i_debug_mode <= 1'b0;
		$display("test loop power down done");
		wr(ADDR_CTRL_TWO, 8'h46);
		count(40, 1);
		rchk(ADDR_STATUS, 8'h17);
		wr(ADDR_CTRL_TWO, 8'h42);
		count(16, 1);
		rchk(ADDR_STATUS, 8'h15);
		$display("test oscillator ready done");
		end_of_test();
	end
endmodule : test_clock_source_unit
